// file: rtl/exception_sequencer.sv
// How it works
// - Accept interrupt, bus error, reset requests
// - Trap, bound and divide instructions raise exceptions
// - Illegal, odd fetch, privilege raise exceptions
// - Trace is internal interrupt, ranked above external interrupts only
// - Four steps: save, vector, stack, fetch
// - Copy status before changing it
// - Set supervisor bit after copy
// - Clear both trace bits on entry
// - Reset and interrupt update priority mask
// - Interrupt vector from acknowledge read cycle
// - Coprocessor vector from its exception primitive
// - Other vectors come from internal logic
// - Frame size by type and point
// - Interrupt with master bit: short master frame
// - Reset clears master bit, fetches vector
// - Master bit set: task uses master stack
// - Interrupt clears master bit in the save step, before stacking on the stack M selected at entry; later exceptions use interrupt stack
// - Vector address is base plus number times four
// - Load fetched vector into program counter
// - Read coprocessor response, serve its primitive
// - Pre, mid or post instruction coprocessor exception
`timescale 1ns/1ns
`include "exc_regs.svh"
module exception_sequencer import exc_pkg::*; (
    input logic core_clk,
    input logic rstn,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [7:0] paddr,
    input logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input logic reset_req_pin,
    input logic bus_error_pin,
    input logic [2:0] irq_level_pin,
    input logic core_exc_req,
    input core_kind_type core_kind,
    input logic [3:0] core_trap_num,
    input logic [31:0] core_fault_addr,
    input logic [31:0] core_pc,
    input logic trace_req,
    input logic cp_resp_valid,
    input logic [15:0] cp_resp,
    output logic bus_req,
    output logic bus_we,
    output logic bus_iack,
    output logic [31:0] bus_addr,
    output logic [31:0] bus_wdata,
    input logic bus_ack,
    input logic [31:0] bus_rdata,
    output logic pc_load,
    output logic [31:0] new_pc,
    output logic busy,
    output logic supervisor,
    output logic cp_service
);
    seq_state_type cur;
    seq_state_type nxt;
    logic win;
    exc_src_type win_src;
    logic [7:0] win_vec;
    logic win_long;
    logic apb_setup;
    logic apb_done;
    logic use_master;
    logic [2:0] frame_n;
    logic [31:0] frame_base;
    logic [15:0] frame_word;
    logic [2:0] cp_kind;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    exc_arbiter u_arb (
        .pend_rst(cur.pend_rst),
        .pend_berr(cur.pend_berr),
        .pend_core(cur.pend_core),
        .core_kind(cur.core_kind),
        .core_trap(cur.core_trap),
        .pend_cp(cur.pend_cp),
        .cp_vec(cur.cp_vec),
        .cp_long(cur.cp_long),
        .pend_trace(cur.pend_trace),
        .irq_level(cur.irq_s2),
        .ipm(cur.sr[`SR_IPM_LSB +: 3]),
        .win(win),
        .win_src(win_src),
        .win_vec(win_vec),
        .win_long(win_long)
    );

    always_comb begin
        use_master = 1'b0;
        frame_n = `FRAME_SHORT_WORDS;
        frame_base = 32'h0;
        frame_word = 16'h0;
        cp_kind = cp_resp[`CP_KIND_LSB +: 3];
        nxt = cur;
        // Pin synchronisers
        nxt.rst_s1 = reset_req_pin;
        nxt.rst_s2 = cur.rst_s1;
        nxt.rst_s3 = cur.rst_s2;
        nxt.berr_s1 = bus_error_pin;
        nxt.berr_s2 = cur.berr_s1;
        nxt.berr_s3 = cur.berr_s2;
        nxt.irq_s1 = irq_level_pin;
        nxt.irq_s2 = cur.irq_s1;
        nxt.pc_load = 1'b0;
        nxt.cp_service = 1'b0;
        nxt.pready = 1'b0;
        nxt.pslverr = 1'b0;

        // APB slave, answer prepared in setup cycle
        apb_setup = psel && !penable;
        apb_done = psel && penable && cur.pready;
        if (apb_setup) begin
            nxt.pready = 1'b1;
            nxt.prdata = 32'h0;
            if (paddr == `SR_OFF) begin
                nxt.prdata = {16'h0, cur.sr};
            end else if (paddr == `VBR_OFF) begin
                nxt.prdata = cur.vector_base_register;
            end else if (paddr == `MSP_OFF) begin
                nxt.prdata = cur.master_stack_pointer;
            end else if (paddr == `ISP_OFF) begin
                nxt.prdata = cur.interrupt_stack_pointer;
            end else if (paddr == `PC_OFF) begin
                nxt.prdata = cur.pc;
            end else if (paddr == `STATUS_OFF) begin
                nxt.prdata = {cur.saved_sr, cur.last_vec, 7'h0, cur.busy};
            end else begin
                nxt.pslverr = 1'b1;
            end
        end
        if (apb_done && pwrite) begin
            if (paddr == `SR_OFF) begin
                nxt.sr = pwdata[15:0];
            end else if (paddr == `VBR_OFF) begin
                nxt.vector_base_register = pwdata;
            end else if (paddr == `MSP_OFF) begin
                nxt.master_stack_pointer = pwdata;
            end else if (paddr == `ISP_OFF) begin
                nxt.interrupt_stack_pointer = pwdata;
            end
        end

        // Stack selection and frame size
        if (cur.src != src_reset) begin
            use_master = cur.sr[`SR_M_BIT];
        end
        if (cur.long_frame && cur.src != src_irq) begin
            frame_n = `FRAME_LONG_WORDS;
        end
        frame_base = (use_master ? cur.master_stack_pointer : cur.interrupt_stack_pointer) - {28'h0, frame_n, 1'b0};
        case (cur.word_idx)
            3'h0: frame_word = cur.saved_sr;
            3'h1: frame_word = cur.frame_pc[31:16];
            3'h2: frame_word = cur.frame_pc[15:0];
            3'h3: frame_word = {(cur.frame_words == `FRAME_LONG_WORDS) ? `FMT_LONG : `FMT_SHORT,
                                2'b00, cur.vec, 2'b00};
            3'h4: frame_word = cur.fault_addr[31:16];
            default: frame_word = cur.fault_addr[15:0];
        endcase

        case (cur.st)
            st_idle: begin
                if (win) begin
                    nxt.saved_sr = cur.sr;
                    nxt.src = win_src;
                    nxt.vec = win_vec;
                    nxt.long_frame = win_long;
                    nxt.irq_lvl = cur.irq_s2;
                    nxt.frame_pc = core_pc;
                    nxt.fault_addr = cur.core_addr;
                    nxt.busy = 1'b1;
                    nxt.st = st_save;
                    case (win_src)
                        src_reset: nxt.pend_rst = 1'b0;
                        src_berr: nxt.pend_berr = 1'b0;
                        src_core: nxt.pend_core = 1'b0;
                        src_cp: nxt.pend_cp = 1'b0;
                        src_trace: nxt.pend_trace = 1'b0;
                        default: nxt.pend_rst = cur.pend_rst;
                    endcase
                end
            end
            st_save: begin
                nxt.sr[`SR_S_BIT] = 1'b1;
                nxt.sr[`SR_T1_BIT] = 1'b0;
                nxt.sr[`SR_T0_BIT] = 1'b0;
                nxt.frame_words = frame_n;
                nxt.sp_work = frame_base;
                nxt.word_idx = 3'h0;
                if (use_master) begin
                    nxt.master_stack_pointer = frame_base;
                end else begin
                    nxt.interrupt_stack_pointer = frame_base;
                end
                if (cur.src == src_reset) begin
                    nxt.sr[`SR_M_BIT] = 1'b0;
                    nxt.sr[`SR_IPM_LSB +: 3] = `IPM_MAX;
                    nxt.interrupt_stack_pointer = cur.interrupt_stack_pointer;
                    nxt.master_stack_pointer = cur.master_stack_pointer;
                    nxt.st = st_fetch;
                end else if (cur.src == src_irq) begin
                    nxt.sr[`SR_M_BIT] = 1'b0;
                    nxt.sr[`SR_IPM_LSB +: 3] = cur.irq_lvl;
                    nxt.bus_req = 1'b1;
                    nxt.bus_we = 1'b0;
                    nxt.bus_iack = 1'b1;
                    nxt.bus_addr = {29'h0, cur.irq_lvl};
                    nxt.st = st_vec;
                end else begin
                    nxt.st = st_stack;
                end
            end
            st_vec: begin
                if (bus_ack) begin
                    nxt.vec = bus_rdata[7:0];
                    nxt.bus_req = 1'b0;
                    nxt.bus_iack = 1'b0;
                    nxt.st = st_stack;
                end
            end
            st_stack: begin
                if (!cur.bus_req) begin
                    nxt.bus_req = 1'b1;
                    nxt.bus_we = 1'b1;
                    nxt.bus_iack = 1'b0;
                    nxt.bus_addr = cur.sp_work + {28'h0, cur.word_idx, 1'b0};
                    nxt.bus_wdata = {16'h0, frame_word};
                end else if (bus_ack) begin
                    nxt.bus_req = 1'b0;
                    if (cur.word_idx == cur.frame_words - 3'h1) begin
                        nxt.st = st_fetch;
                    end else begin
                        nxt.word_idx = cur.word_idx + 3'h1;
                    end
                end
            end
            st_fetch: begin
                if (!cur.bus_req) begin
                    nxt.bus_req = 1'b1;
                    nxt.bus_we = 1'b0;
                    nxt.bus_iack = 1'b0;
                    nxt.bus_addr = cur.vector_base_register + {22'h0, cur.vec, 2'b00};
                end else if (bus_ack) begin
                    nxt.bus_req = 1'b0;
                    nxt.pc = bus_rdata;
                    nxt.st = st_done;
                end
            end
            default: begin
                nxt.pc_load = 1'b1;
                nxt.last_vec = cur.vec;
                nxt.busy = 1'b0;
                nxt.st = st_idle;
            end
        endcase

        // A pending reset abandons whatever sequence is running
        if (cur.pend_rst && cur.st != st_idle) begin
            nxt.st = st_idle;
            nxt.bus_req = 1'b0;
            nxt.bus_iack = 1'b0;
            nxt.busy = 1'b0;
        end

        // New events last so that a set beats a same-cycle clear
        if (cur.rst_s2 && !cur.rst_s3) begin
            nxt.pend_rst = 1'b1;
        end
        if (cur.berr_s2 && !cur.berr_s3) begin
            nxt.pend_berr = 1'b1;
        end
        if (cp_resp_valid) begin
            if (cp_kind == `CP_PRIV) begin
                if (!cur.sr[`SR_S_BIT]) begin
                    nxt.pend_core = 1'b1;
                    nxt.core_kind = k_priv;
                end
            end else if (cp_kind == `CP_PRE || cp_kind == `CP_MID || cp_kind == `CP_POST) begin
                nxt.pend_cp = 1'b1;
                nxt.cp_vec = cp_resp[7:0];
                nxt.cp_long = (cp_kind != `CP_PRE);
            end else begin
                nxt.cp_service = 1'b1;
            end
        end
        if (core_exc_req) begin
            nxt.pend_core = 1'b1;
            nxt.core_kind = core_kind;
            nxt.core_trap = core_trap_num;
            nxt.core_addr = core_fault_addr;
        end
        if (trace_req) begin
            nxt.pend_trace = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cur <= '0;
            cur.pend_rst <= 1'b1;
            cur.sr <= `SR_RESET;
        end else begin
            cur <= nxt;
        end
    end

    assign prdata = cur.prdata;
    assign pready = cur.pready;
    assign pslverr = cur.pslverr;
    assign bus_req = cur.bus_req;
    assign bus_we = cur.bus_we;
    assign bus_iack = cur.bus_iack;
    assign bus_addr = cur.bus_addr;
    assign bus_wdata = cur.bus_wdata;
    assign pc_load = cur.pc_load;
    assign new_pc = cur.pc;
    assign busy = cur.busy;
    assign supervisor = cur.sr[`SR_S_BIT];
    assign cp_service = cur.cp_service;

    a_status_copy: assert property ((cur.st == st_idle && win && !cur.pend_rst)
        |=> cur.saved_sr == $past(cur.sr))
        else $error("saved status differs from status at entry");
    a_supervisor_set: assert property ((cur.st == st_save && !cur.pend_rst)
        |=> cur.sr[`SR_S_BIT])
        else $error("supervisor bit not set after save step");
    a_trace_cleared: assert property ((cur.st == st_save && !cur.pend_rst)
        |=> !cur.sr[`SR_T1_BIT] && !cur.sr[`SR_T0_BIT])
        else $error("trace bits not cleared on entry");
    a_reset_mask: assert property ((cur.st == st_save && cur.src == src_reset && !cur.pend_rst)
        |=> cur.sr[`SR_IPM_LSB +: 3] == `IPM_MAX && !cur.sr[`SR_M_BIT]
            && cur.st == st_fetch)
        else $error("reset entry did not set mask and clear master bit");
    a_irq_master_off: assert property ((cur.st == st_save && cur.src == src_irq
        && !cur.pend_rst) |=> !cur.sr[`SR_M_BIT]
            && cur.sr[`SR_IPM_LSB +: 3] == $past(cur.irq_lvl) && cur.bus_iack)
        else $error("interrupt entry state wrong");
    a_iack_read: assert property ((cur.bus_req && cur.bus_iack)
        |-> !cur.bus_we && cur.st == st_vec)
        else $error("acknowledge cycle is not a read");
    a_irq_short: assert property ((cur.st == st_stack && cur.src == src_irq)
        |-> cur.frame_words == `FRAME_SHORT_WORDS)
        else $error("interrupt frame is not four words");
    a_vector_addr: assert property ((cur.st == st_fetch && cur.bus_req)
        |-> cur.bus_addr == cur.vector_base_register + {22'h0, cur.vec, 2'b00} && !cur.bus_we)
        else $error("vector address wrong");
    a_pc_loaded: assert property ((cur.st == st_fetch && cur.bus_req && bus_ack
        && !cur.pend_rst) |=> ##1 cur.pc_load && cur.pc == $past(bus_rdata, 2))
        else $error("vector not loaded into program counter");
    a_reset_abandon: assert property ((cur.pend_rst && cur.st != st_idle)
        |=> cur.st == st_idle && !cur.bus_req)
        else $error("reset did not abandon sequence");
    a_step_order: assert property ((cur.st == st_save)
        |=> cur.st == st_vec || cur.st == st_stack || cur.st == st_fetch
            || cur.st == st_idle)
        else $error("step order broken");

    c_irq_done: cover property (cur.src == src_irq && cur.pc_load);
    c_reset_done: cover property (cur.src == src_reset && cur.pc_load);
    c_cp_long: cover property (cur.src == src_cp && cur.st == st_stack
        && cur.frame_words == `FRAME_LONG_WORDS);
    c_master_irq: cover property (cur.st == st_save && cur.src == src_irq
        && cur.sr[`SR_M_BIT]);
endmodule

// file: rtl/exc_regs.svh
`ifndef EXC_REGS_SVH
`define EXC_REGS_SVH

// Register byte offsets
`define SR_OFF 8'h00
`define VBR_OFF 8'h04
`define MSP_OFF 8'h08
`define ISP_OFF 8'h0C
`define PC_OFF 8'h10
`define STATUS_OFF 8'h14

// Status register fields and reset value
`define SR_T1_BIT 15
`define SR_T0_BIT 14
`define SR_S_BIT 13
`define SR_M_BIT 12
`define SR_IPM_LSB 8
`define SR_RESET 16'h2700
`define IPM_MAX 3'h7

// Internally generated vector numbers
`define VEC_RESET 8'h00
`define VEC_BERR 8'h02
`define VEC_ODD 8'h03
`define VEC_ILLEGAL 8'h04
`define VEC_DIVIDE 8'h05
`define VEC_BOUND 8'h06
`define VEC_COND_TRAP 8'h07
`define VEC_PRIV 8'h08
`define VEC_TRACE 8'h09
`define VEC_TRAP_BASE 8'h20

// Stack frame formats and sizes in 16-bit words
`define FMT_SHORT 4'h0
`define FMT_LONG 4'h2
`define FRAME_SHORT_WORDS 3'h4
`define FRAME_LONG_WORDS 3'h6

// Coprocessor response primitive kinds in bits 15:13
`define CP_KIND_LSB 13
`define CP_PRIV 3'h4
`define CP_PRE 3'h5
`define CP_MID 3'h6
`define CP_POST 3'h7

`endif

// file: rtl/exc_pkg.sv
package exc_pkg;

typedef enum logic [2:0] {
    st_idle, st_save, st_vec, st_stack, st_fetch, st_done
} exc_state_type;

typedef enum logic [2:0] {
    src_reset, src_berr, src_core, src_cp, src_trace, src_irq
} exc_src_type;

typedef enum logic [3:0] {
    k_trap, k_cond_trap, k_ovf_trap, k_coproc_trap, k_bound, k_dual_bound,
    k_divide, k_illegal, k_odd, k_priv
} core_kind_type;

typedef struct packed {
    exc_state_type st;
    logic rst_s1;
    logic rst_s2;
    logic rst_s3;
    logic berr_s1;
    logic berr_s2;
    logic berr_s3;
    logic [2:0] irq_s1;
    logic [2:0] irq_s2;
    logic pend_rst;
    logic pend_berr;
    logic pend_core;
    logic pend_cp;
    logic pend_trace;
    core_kind_type core_kind;
    logic [3:0] core_trap;
    logic [31:0] core_addr;
    logic [7:0] cp_vec;
    logic cp_long;
    logic long_frame;
    logic [15:0] sr;
    logic [15:0] saved_sr;
    logic [31:0] vector_base_register;
    logic [31:0] master_stack_pointer;
    logic [31:0] interrupt_stack_pointer;
    logic [31:0] pc;
    logic [31:0] frame_pc;
    logic [31:0] fault_addr;
    logic [31:0] sp_work;
    exc_src_type src;
    logic [7:0] vec;
    logic [7:0] last_vec;
    logic [2:0] irq_lvl;
    logic [2:0] word_idx;
    logic [2:0] frame_words;
    logic busy;
    logic bus_req;
    logic bus_we;
    logic bus_iack;
    logic [31:0] bus_addr;
    logic [31:0] bus_wdata;
    logic pc_load;
    logic cp_service;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
} seq_state_type;

endpackage

// file: rtl/exc_arbiter.sv
`timescale 1ns/1ns
`include "exc_regs.svh"
module exc_arbiter import exc_pkg::*; (
    input logic pend_rst,
    input logic pend_berr,
    input logic pend_core,
    input core_kind_type core_kind,
    input logic [3:0] core_trap,
    input logic pend_cp,
    input logic [7:0] cp_vec,
    input logic cp_long,
    input logic pend_trace,
    input logic [2:0] irq_level,
    input logic [2:0] ipm,
    output logic win,
    output exc_src_type win_src,
    output logic [7:0] win_vec,
    output logic win_long
);
    always_comb begin
        win = 1'b1;
        win_src = src_reset;
        win_vec = `VEC_RESET;
        win_long = 1'b0;
        if (pend_rst) begin
            win_src = src_reset;
        end else if (pend_berr) begin
            win_src = src_berr;
            win_vec = `VEC_BERR;
            win_long = 1'b1;
        end else if (pend_core) begin
            win_src = src_core;
            win_long = 1'b1;
            case (core_kind)
                k_trap: begin
                    win_vec = `VEC_TRAP_BASE | {4'h0, core_trap};
                    win_long = 1'b0;
                end
                k_cond_trap, k_ovf_trap, k_coproc_trap: win_vec = `VEC_COND_TRAP;
                k_bound, k_dual_bound: win_vec = `VEC_BOUND;
                k_divide: win_vec = `VEC_DIVIDE;
                k_odd: win_vec = `VEC_ODD;
                k_priv: begin
                    win_vec = `VEC_PRIV;
                    win_long = 1'b0;
                end
                default: begin
                    win_vec = `VEC_ILLEGAL;
                    win_long = 1'b0;
                end
            endcase
        end else if (pend_cp) begin
            win_src = src_cp;
            win_vec = cp_vec;
            win_long = cp_long;
        end else if (pend_trace) begin
            win_src = src_trace;
            win_vec = `VEC_TRACE;
            win_long = 1'b1;
        end else if (irq_level != 3'h0 && (irq_level == `IPM_MAX || irq_level > ipm)) begin
            win_src = src_irq;
        end else begin
            win = 1'b0;
        end
    end
endmodule

// file: test/exc_bus_model.sv
`timescale 1ns/1ns
module exc_bus_model (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic bus_req,
    input wire logic bus_we,
    input wire logic bus_iack,
    input wire logic [31:0] bus_addr,
    input wire logic [31:0] bus_wdata,
    input wire logic [3:0] dly,
    input wire logic [7:0] irq_vec,
    output logic bus_ack,
    output logic [31:0] bus_rdata
);
    logic [3:0] cnt;
    logic [31:0] last = 32'h0;
    logic [31:0] ia = 32'h0;
    logic [31:0] wa[256];
    logic [15:0] wd[256];
    int wn = 0;
    assign bus_ack = bus_req && (cnt >= dly);
    // Vector table holds 0x1000_0000 plus the entry address
    always_comb begin
        if (!bus_ack) bus_rdata = ~last;
        else if (bus_iack) bus_rdata = {24'h0, irq_vec};
        else bus_rdata = 32'h1000_0000 + bus_addr;
    end
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cnt <= 4'h0;
        end else begin
            cnt <= (bus_req && !bus_ack) ? cnt + 4'h1 : 4'h0;
            if (bus_ack) begin
                last <= bus_rdata;
                if (bus_iack) ia <= bus_addr;
                if (bus_we) begin
                    wa[wn] <= bus_addr;
                    wd[wn] <= bus_wdata[15:0];
                    wn <= wn + 1;
                end
            end
        end
    end
endmodule

// file: test/testbench.sv
`timescale 1ns/1ns
module testbench import exc_pkg::*; ();
    logic core_clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
    logic reset_req_pin = 0, bus_error_pin = 0, core_exc_req = 0, trace_req = 0;
    logic cp_resp_valid = 0, e, pready, pslverr, bus_req, bus_we, bus_iack, bus_ack;
    logic pc_load, busy, supervisor, cp_service;
    logic [7:0] paddr = 8'h00, irq_vec = 8'h40;
    logic [2:0] irq_level_pin = 3'h0;
    logic [3:0] core_trap_num = 4'h3, dly = 4'h0;
    logic [15:0] cp_resp = 16'h0000;
    logic [31:0] pwdata = 32'h0, core_fault_addr = 32'h0ABC, core_pc = 32'h4000;
    logic [31:0] prdata, bus_addr, bus_wdata, bus_rdata, new_pc, r, vector_base_register = 32'h0;
    core_kind_type core_kind = k_trap;
    logic [7:0] vt[10] = '{8'h23, 8'h07, 8'h07, 8'h07, 8'h06, 8'h06, 8'h05, 8'h04, 8'h03, 8'h08};
    int wt[10] = '{4, 6, 6, 6, 6, 6, 6, 4, 6, 4};
    int err_total = 0, check_count = 0, w0 = 0, n;

    exception_sequencer u_exception_sequencer (
        .core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .reset_req_pin(reset_req_pin),
        .bus_error_pin(bus_error_pin), .irq_level_pin(irq_level_pin),
        .core_exc_req(core_exc_req), .core_kind(core_kind), .core_trap_num(core_trap_num),
        .core_fault_addr(core_fault_addr), .core_pc(core_pc), .trace_req(trace_req),
        .cp_resp_valid(cp_resp_valid), .cp_resp(cp_resp), .bus_req(bus_req),
        .bus_we(bus_we), .bus_iack(bus_iack), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_ack(bus_ack), .bus_rdata(bus_rdata), .pc_load(pc_load), .new_pc(new_pc),
        .busy(busy), .supervisor(supervisor), .cp_service(cp_service));
    exc_bus_model u_exc_bus_model (
        .core_clk(core_clk), .rstn(rstn), .bus_req(bus_req), .bus_we(bus_we),
        .bus_iack(bus_iack), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .dly(dly),
        .irq_vec(irq_vec), .bus_ack(bus_ack), .bus_rdata(bus_rdata));

    always #4 core_clk = ~core_clk;

    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) err_total++;
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, exp, r);
    endtask
    // Request pulses last one cycle, the bus error pin four
    task fire(input int k);
        w0 = u_exc_bus_model.wn;
        @(posedge core_clk);
        case (k)
            0: core_exc_req <= 1'b1;
            1: trace_req <= 1'b1;
            2: cp_resp_valid <= 1'b1;
            default: bus_error_pin <= 1'b1;
        endcase
        @(posedge core_clk);
        core_exc_req <= 1'b0;
        trace_req <= 1'b0;
        cp_resp_valid <= 1'b0;
        repeat (3) @(posedge core_clk);
        bus_error_pin <= 1'b0;
    endtask
    task take(input logic [7:0] v, input int words);
        for (n = 0; n < 400 && pc_load !== 1'b1; n++) @(posedge core_clk);
        chk("pc_load", 32'h1, {31'h0, pc_load});
        chk("busy_end", 32'h0, {31'h0, busy});
        chk("supervisor", 32'h1, {31'h0, supervisor});
        chk("new_pc", 32'h1000_0000 + vector_base_register + {22'h0, v, 2'b00}, new_pc);
        if (words >= 0) chk("frame_words", words, u_exc_bus_model.wn - w0);
        @(posedge core_clk);
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        #100000;
        err_total++;
        report_and_stop;
    end

    initial begin
        repeat (4) @(posedge core_clk);
        rstn <= 1'b1;
        take(8'h00, 0);
        rd(8'h00, 32'h2700, "sr_reset");
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped_err", 32'h1, {31'h0, e});
        vector_base_register = 32'h100;
        apb(1'b1, 8'h04, vector_base_register);
        rd(8'h04, vector_base_register, "vbr");
        apb(1'b1, 8'h08, 32'h2000);
        apb(1'b1, 8'h00, 32'h9000);
        core_kind <= k_illegal;
        fire(0);
        take(8'h04, 4);
        chk("msp_frame", 32'h1FF8, u_exc_bus_model.wa[w0]);
        chk("saved_sr", 32'h9000, {16'h0, u_exc_bus_model.wd[w0]});
        rd(8'h00, 32'h3000, "sr_entry");
        rd(8'h14, 32'h9000_0400, "status");
        apb(1'b1, 8'h08, 32'h3000);
        apb(1'b1, 8'h0C, 32'h4000);
        dly <= 4'h3;
        w0 = u_exc_bus_model.wn;
        irq_level_pin <= 3'h5;
        take(8'h40, 4);
        irq_level_pin <= 3'h0;
        chk("iack_addr", 32'h5, u_exc_bus_model.ia);
        chk("master_frame", 32'h2FF8, u_exc_bus_model.wa[w0]);
        rd(8'h00, 32'h2500, "sr_irq");
        w0 = u_exc_bus_model.wn;
        irq_level_pin <= 3'h6;
        take(8'h40, 4);
        irq_level_pin <= 3'h0;
        chk("isp_frame", 32'h3FF8, u_exc_bus_model.wa[w0]);
        dly <= 4'h0;
        for (int i = 0; i < 10; i++) begin
            core_kind <= core_kind_type'(i[3:0]);
            fire(0);
            take(vt[i], wt[i]);
        end
        fire(1);
        take(8'h09, 6);
        fire(3);
        take(8'h02, 6);
        for (int i = 5; i < 8; i++) begin
            cp_resp <= {i[2:0], 13'h0038};
            fire(2);
            take(8'h38, i == 5 ? 4 : 6);
        end
        cp_resp <= 16'h2000;
        @(posedge core_clk);
        cp_resp_valid <= 1'b1;
        @(posedge core_clk);
        cp_resp_valid <= 1'b0;
        @(posedge core_clk);
        chk("cp_service", 32'h1, {31'h0, cp_service});
        apb(1'b1, 8'h00, 32'h0);
        cp_resp <= 16'h8038;
        fire(2);
        take(8'h08, 4);
        dly <= 4'h6;
        fire(3);
        for (n = 0; n < 100 && u_exc_bus_model.wn == w0; n++) @(posedge core_clk);
        chk("busy_run", 32'h1, {31'h0, busy});
        reset_req_pin <= 1'b1;
        repeat (4) @(posedge core_clk);
        reset_req_pin <= 1'b0;
        take(8'h00, -1);
        chk("abandoned", 32'h1, {31'h0, (u_exc_bus_model.wn - w0) < 6});
        rd(8'h00, 32'h2700, "sr_rereset");
        report_and_stop;
    end
endmodule
